/* design/timer_pkg.sv */
// Functional notes
// [R1] Counter and reload register share one address
// [R2] Decrement per tick; reload after reaching zero
// [R3] Idle or pre-first-tick writes load both
// [R4] Later writes update only the reload register
// [R5] Period is loaded value plus one ticks
// [R6] Start flag one runs, zero stops
// [R7] Counter reads return the live count
// [R8] Option bit picks narrow or wide code
// [R9] Narrow code: base, div8, div32, subclock
// [R10] Wide code adds div64 and slow oscillator
// [R11] Halve select picks base or base/2
// [R12] Software enables base clock before use
// [R13] Prescaler reset write clears the divider
// [R14] Mode field zero selects timer mode
// [R15] Mode-dependent bits written zero, read undefined
// [R16] Underflow request lasts one tick; pin free
package timer_pkg;

	// Register indices; byte address is four times the index
	localparam logic [9:0] IDX_COUNTER = 10'h330;
	localparam logic [9:0] IDX_START = 10'h320;
	localparam logic [9:0] IDX_MODE = 10'h33b;
	localparam logic [9:0] IDX_SRC_SEL = 10'h31b;
	localparam logic [9:0] IDX_PCLK = 10'h312;
	localparam logic [9:0] IDX_CLK_STOP = 10'h311;
	localparam logic [9:0] IDX_PRESCALE = 10'h315;
	localparam logic [9:0] IDX_STATUS = 10'h340;
	localparam logic [9:0] IDX_MASK = 10'h341;

	// Reset values
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [3:0] SRC_SEL_RESET = 4'h0;
	localparam logic PCLK_RESET = 1'b0;
	localparam logic CLK_STOP_RESET = 1'b1;
	localparam logic START_RESET = 1'b0;
	localparam logic MASK_RESET = 1'b0;

	// Field positions
	localparam int MODE_OP_LSB = 0;
	localparam int MODE_NARROW_LSB = 6;
	localparam int SRC_WIDE_LSB = 0;
	localparam int SRC_OPTION_BIT = 3;

	// Mode and source codes
	localparam logic [1:0] OP_TIMER = 2'h0;
	localparam logic [1:0] NARROW_BASE = 2'h0;
	localparam logic [1:0] NARROW_DIV8 = 2'h1;
	localparam logic [1:0] NARROW_DIV32 = 2'h2;
	localparam logic [1:0] NARROW_SUB = 2'h3;
	localparam logic [2:0] WIDE_BASE = 3'h0;
	localparam logic [2:0] WIDE_DIV8 = 3'h1;
	localparam logic [2:0] WIDE_DIV32 = 3'h2;
	localparam logic [2:0] WIDE_DIV64 = 3'h3;
	localparam logic [2:0] WIDE_SLOW = 3'h5;
	localparam logic [2:0] WIDE_SUB = 3'h6;

	// Prescaler width: enough for divide by 64
	localparam int PRESCALE_W = 6;

	// Address phase as latched by the bus slave
	typedef struct packed {
		logic [9:0] index;
		logic mapped;
	} bus_phase_type;

	// Count source control handed to the prescaler
	typedef struct packed {
		logic [2:0] wide_code;
		logic base_full;
		logic base_stop;
		logic clear;
	} source_ctrl_type;

endpackage : timer_pkg

/* design/count_source_prescaler.sv */
`timescale 1ns/10ps
`default_nettype none
module count_source_prescaler
	import timer_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Source control
	input wire source_ctrl_type ctrl,
	// Asynchronous clock pins
	input wire logic slow_oscillator_clock,
	input wire logic subclock_32k,
	// Selected count-source pulse
	output logic tick
);

	// Free-running divider of the base clock
	logic [PRESCALE_W-1:0] divider;
	// Edge pulses from the asynchronous sources
	logic [1:0] ext_edge;
	// Combinational pick before the output flop
	logic next_tick;

	// Divider; a prescaler reset restarts every division
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			divider <= '0;
		end else if (ctrl.clear) begin
			divider <= '0; // [R13]
		end else begin
			divider <= divider + 1'b1;
		end
	end

	// Synchronise both slow pins; edge once stages two and three agree
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gen_sync
			logic [2:0] stage;
			logic agreed;
			logic pin;
			assign pin = (g == 0) ? slow_oscillator_clock : subclock_32k;
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					stage <= 3'h0;
					agreed <= 1'b0;
				end else begin
					stage <= {stage[1:0], pin};
					// Only a settled level moves the agreed value
					if (stage[1] == stage[2]) begin
						agreed <= stage[2];
					end
				end
			end
			assign ext_edge[g] = (stage[1] == stage[2]) && stage[2] && !agreed;
		end
	endgenerate

	// Source pick; base-derived ticks die while the base clock stops
	always_comb begin
		next_tick = 1'b0;
		case (ctrl.wide_code)
			WIDE_BASE: begin
				next_tick = ctrl.base_full ? 1'b1 : divider[0]; // [R11]
			end
			WIDE_DIV8: begin
				next_tick = &divider[2:0];
			end
			WIDE_DIV32: begin
				next_tick = &divider[4:0];
			end
			WIDE_DIV64: begin
				next_tick = &divider[5:0];
			end
			default: begin
				next_tick = 1'b0;
			end
		endcase
		if (ctrl.base_stop || ctrl.clear) begin
			next_tick = 1'b0;
		end
		// Oscillator sources do not depend on the base clock
		if (ctrl.wide_code == WIDE_SLOW) begin
			next_tick = ext_edge[0]; // [R10]
		end
		if (ctrl.wide_code == WIDE_SUB) begin
			next_tick = ext_edge[1];
		end
	end

	// Registered so the counter sees a clean one-cycle pulse, or a steady high for the full base clock
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tick <= 1'b0;
		end else begin
			tick <= next_tick;
		end
	end

endmodule : count_source_prescaler
`default_nettype wire

/* design/reload_down_timer.sv */
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
module reload_down_timer
	import timer_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Count source pins
	input wire logic slow_oscillator_clock,
	input wire logic subclock_32k,
	// Underflow request and interrupt
	output logic underflow_request,
	output logic irq,
	// Input pin ownership
	output logic channel_input_pin_claim
);

	// Data-phase tracking of the bus slave
	typedef enum logic [1:0] {
		DP_IDLE,
		DP_WRITE,
		DP_READ_WAIT,
		DP_READ_DONE
	} data_phase_type;

	data_phase_type phase_state;
	// Latched address phase
	bus_phase_type phase;
	// Decoded new address phase
	bus_phase_type next_phase;
	logic take_addr;

	// Software-visible state
	logic [15:0] count;
	logic [15:0] reload;
	logic channel_start_flag;
	logic [1:0] operation_mode_field;
	logic [1:0] narrow_source_code;
	logic [2:0] wide_source_code;
	logic source_option_bit;
	logic base_clock_halve_select;
	logic base_clock_stop_bit;
	logic prescaler_clear;
	logic status_underflow;
	logic mask_underflow;

	// Internal control
	logic first_tick_seen;
	logic tick;
	logic running;
	logic write_strobe;
	logic wr_counter;
	logic wr_counter_both;
	logic underflow;
	logic [31:0] read_value;
	source_ctrl_type source_ctrl;

	// Address phase accepted only on a real transfer with the bus ready
	assign take_addr = hsel && htrans[1] && hready;

	// Decode; upper address bits must be zero to count as mapped
	always_comb begin
		next_phase.index = haddr[11:2];
		next_phase.mapped = (haddr[31:12] == 20'h00000);
	end

	// Data-phase sequencer; reads insert one wait state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_state <= DP_IDLE;
			phase <= '0;
		end else begin
			unique case (phase_state)
				DP_READ_WAIT: begin
					phase_state <= DP_READ_DONE;
				end
				DP_IDLE, DP_WRITE, DP_READ_DONE: begin
					if (take_addr) begin
						phase <= next_phase;
						phase_state <= hwrite ? DP_WRITE : DP_READ_WAIT;
					end else begin
						phase_state <= DP_IDLE;
					end
				end
			endcase
		end
	end

	// The wait state lets a read follow a write to the same register
	assign hreadyout = (phase_state != DP_READ_WAIT);
	// Every transfer answers OKAY
	assign hresp = 1'b0;
	// Unmapped writes fall through every decode below
	assign write_strobe = (phase_state == DP_WRITE) && phase.mapped;
	assign wr_counter = write_strobe && (phase.index == IDX_COUNTER);

	// Timer mode only; other modes hold the counter still
	assign running = channel_start_flag &&
		(operation_mode_field == OP_TIMER); // [R6] [R14]

	// Immediate load while stopped or before the first tick
	assign wr_counter_both = wr_counter &&
		(!running || !first_tick_seen); // [R3]

	// Underflow: a tick reaching a zero counter that is not overwritten
	assign underflow = running && tick && (count == 16'h0000) &&
		!wr_counter_both;

	// Timer mode never drives or samples the input pin
	assign channel_input_pin_claim = 1'b0; // [R16]

	// Start flag
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			channel_start_flag <= START_RESET;
		end else if (write_strobe && (phase.index == IDX_START)) begin
			channel_start_flag <= hwdata[0]; // [R6]
		end
	end

	// Mode register; only the operation and narrow source fields store
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			operation_mode_field <= MODE_RESET[MODE_OP_LSB +: 2];
			narrow_source_code <= MODE_RESET[MODE_NARROW_LSB +: 2];
		end else if (write_strobe && (phase.index == IDX_MODE)) begin
			operation_mode_field <= hwdata[MODE_OP_LSB +: 2]; // [R14]
			narrow_source_code <= hwdata[MODE_NARROW_LSB +: 2];
		end
	end

	// Shared source-select register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wide_source_code <= SRC_SEL_RESET[SRC_WIDE_LSB +: 3];
			source_option_bit <= SRC_SEL_RESET[SRC_OPTION_BIT];
		end else if (write_strobe && (phase.index == IDX_SRC_SEL)) begin
			wide_source_code <= hwdata[SRC_WIDE_LSB +: 3];
			source_option_bit <= hwdata[SRC_OPTION_BIT];
		end
	end

	// Base clock halve select
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			base_clock_halve_select <= PCLK_RESET;
		end else if (write_strobe && (phase.index == IDX_PCLK)) begin
			base_clock_halve_select <= hwdata[0];
		end
	end

	// Base clock stop; starts stopped so software must enable it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			base_clock_stop_bit <= CLK_STOP_RESET;
		end else if (write_strobe && (phase.index == IDX_CLK_STOP)) begin
			base_clock_stop_bit <= hwdata[0]; // [R12]
		end
	end

	// Prescaler reset; a one-cycle pulse, writing zero does nothing
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prescaler_clear <= 1'b0;
		end else begin
			prescaler_clear <= write_strobe &&
				(phase.index == IDX_PRESCALE) && hwdata[0]; // [R13]
		end
	end

	// Source selection; the option bit picks which field is live
	always_comb begin
		source_ctrl.wide_code = WIDE_BASE;
		if (source_option_bit) begin
			source_ctrl.wide_code = wide_source_code; // [R8]
		end else begin
			// Narrow codes mapped onto the wide encoding
			unique case (narrow_source_code)
				NARROW_BASE: source_ctrl.wide_code = WIDE_BASE; // [R9]
				NARROW_DIV8: source_ctrl.wide_code = WIDE_DIV8;
				NARROW_DIV32: source_ctrl.wide_code = WIDE_DIV32;
				NARROW_SUB: source_ctrl.wide_code = WIDE_SUB;
			endcase
		end
		source_ctrl.base_full = base_clock_halve_select; // [R11]
		source_ctrl.base_stop = base_clock_stop_bit;
		source_ctrl.clear = prescaler_clear;
	end

	// Count-source generator
	count_source_prescaler u_prescaler (
		.hclk(hclk),
		.hresetn(hresetn),
		.ctrl(source_ctrl),
		.slow_oscillator_clock(slow_oscillator_clock),
		.subclock_32k(subclock_32k),
		.tick(tick)
	);

	// First tick after start; decides where counter writes go
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			first_tick_seen <= 1'b0;
		end else if (!running) begin
			first_tick_seen <= 1'b0;
		end else if (tick) begin
			first_tick_seen <= 1'b1; // [R4]
		end
	end

	// Reload register takes every counter write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			reload <= COUNT_RESET;
		end else if (wr_counter) begin
			reload <= hwdata[15:0]; // [R1] [R4]
		end
	end

	// Down-counter; zero then one more tick gives n plus one ticks
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count <= COUNT_RESET;
		end else if (wr_counter_both) begin
			// A write in the same cycle as the first tick still loads
			count <= hwdata[15:0]; // [R1] [R3]
		end else if (running && tick) begin
			if (count == 16'h0000) begin
				count <= reload; // [R2] [R5]
			end else begin
				count <= count - 16'h0001; // [R2]
			end
		end
	end

	// Underflow request held for one count-source period
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			underflow_request <= 1'b0;
		end else if (underflow) begin
			underflow_request <= 1'b1; // [R16]
		end else if (tick || !running) begin
			// Stopping drops it; no further tick would end it
			underflow_request <= 1'b0;
		end
	end

	// Sticky status; a new underflow beats a clear in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_underflow <= 1'b0;
		end else if (underflow) begin
			status_underflow <= 1'b1;
		end else if (write_strobe && (phase.index == IDX_STATUS) &&
			hwdata[0]) begin
			status_underflow <= 1'b0;
		end
	end

	// Interrupt mask
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mask_underflow <= MASK_RESET;
		end else if (write_strobe && (phase.index == IDX_MASK)) begin
			mask_underflow <= hwdata[0];
		end
	end

	// Level interrupt from unmasked status
	assign irq = status_underflow && mask_underflow;

	// Read mux; unused bits and unmapped addresses read zero
	always_comb begin
		read_value = 32'h00000000;
		if (phase.mapped) begin
			unique case (phase.index)
				IDX_COUNTER: begin
					read_value[15:0] = count; // [R7]
				end
				IDX_START: begin
					read_value[0] = channel_start_flag;
				end
				IDX_MODE: begin
					// Mode-dependent bit reads back as zero here
					read_value[MODE_OP_LSB +: 2] = operation_mode_field; // [R15]
					read_value[MODE_NARROW_LSB +: 2] = narrow_source_code;
				end
				IDX_SRC_SEL: begin
					read_value[SRC_WIDE_LSB +: 3] = wide_source_code;
					read_value[SRC_OPTION_BIT] = source_option_bit;
				end
				IDX_PCLK: begin
					read_value[0] = base_clock_halve_select;
				end
				IDX_CLK_STOP: begin
					read_value[0] = base_clock_stop_bit;
				end
				IDX_STATUS: begin
					read_value[0] = status_underflow;
				end
				IDX_MASK: begin
					read_value[0] = mask_underflow;
				end
				default: begin
					// Includes the prescaler reset, which reads zero
					read_value = 32'h00000000;
				end
			endcase
		end
	end

	// Read data captured during the wait state, held until next read
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (phase_state == DP_READ_WAIT) begin
			hrdata <= read_value;
		end
	end

endmodule : reload_down_timer
`default_nettype wire

/* verification/reload_down_timer_properties.sv */
`timescale 1ns/10ps
`default_nettype none
// Port-level checks of the timer's bus slave and request outputs
module reload_down_timer_properties (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Bus request side
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	// Bus answer side
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	// Timer outputs
	input wire logic underflow_request,
	input wire logic irq,
	input wire logic channel_input_pin_claim
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// Transfer taken at this edge
	wire logic taken = hsel & htrans[1] & hready;
	// Write taken at this edge
	wire logic wr_now = taken & hwrite;

	// Read address phase accepted
	sequence rd_taken;
		taken && !hwrite;
	endsequence
	// Exactly one wait cycle, then ready
	sequence one_wait;
		!hreadyout ##1 hreadyout;
	endsequence

	read_wait_a: assert property (rd_taken |=> one_wait)
		else $error("read wait state count wrong");
	write_nowait_a: assert property (wr_now |=> hreadyout)
		else $error("write data phase stalled");
	single_wait_a: assert property (!hreadyout |=> hreadyout)
		else $error("wait state held too long");
	rdata_hold_a: assert property ($changed(hrdata) |->
		!$past(hreadyout))
		else $error("read data changed outside a read");
	upper_zero_a: assert property (hrdata[31:16] == 16'h0)
		else $error("unused read data bits set");
	okay_resp_a: assert property (hresp == 1'b0)
		else $error("response not okay");
	pin_free_a: assert property (channel_input_pin_claim == 1'b0)
		else $error("input pin claimed in timer mode");
	// Interrupt only rises with an underflow or a register write
	irq_cause_a: assert property ($rose(irq) |->
		underflow_request || $past(wr_now, 2))
		else $error("interrupt rose without cause");
	irq_clear_a: assert property ($fell(irq) |-> $past(wr_now, 2))
		else $error("interrupt fell without a write");
endmodule : reload_down_timer_properties
`default_nettype wire

/* verification/reload_down_timer_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module reload_down_timer_tb
	import timer_pkg::*;
;
	// Clock, reset and bus master signals
	logic hclk, hresetn, hsel, hwrite;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	// Slave answers and timer outputs
	logic hreadyout, hresp, underflow_request, irq, channel_input_pin_claim;
	wire logic hready = hreadyout;
	// Asynchronous count source pins and their divider
	logic slow_oscillator_clock, subclock_32k;
	logic [7:0] div_cnt;
	// Expected reads {check irq, irq, data} and underflow spacings
	logic [33:0] exp_q[$];
	int per_q[$];
	logic [33:0] e;
	int n_fail, checks_done, cyc, last_rise;
	logic rd_phase, req_q;
	logic [15:0] v;

	reload_down_timer u_reload_down_timer (.hclk, .hresetn, .hsel, .haddr,
		.htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp,
		.hrdata, .slow_oscillator_clock, .subclock_32k, .underflow_request,
		.irq, .channel_input_pin_claim);

	// 40 MHz clock
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end

	// Slow oscillator every 8 cycles, subclock every 16
	always @(posedge hclk) begin
		div_cnt <= div_cnt + 8'h01;
		slow_oscillator_clock <= div_cnt[2];
		subclock_32k <= div_cnt[3];
	end

	// Scoreboard: completed reads and spacing of underflow pulses
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		req_q <= underflow_request;
		if (rd_phase && hreadyout === 1'b1) begin
			e = exp_q.pop_front();
			checks_done++;
			if (hrdata !== e[31:0] || (e[33] && irq !== e[32])) begin
				n_fail++;
				$display("MISMATCH %0t read %h exp %h irq %b", $time,
					hrdata, e[31:0], irq);
			end
		end
		// Data phase of a read in progress
		if (hreadyout)
			rd_phase <= hsel && htrans[1] && !hwrite;
		if (underflow_request === 1'b1 && req_q === 1'b0) begin
			if (per_q.size() > 0) begin
				checks_done++;
				if (cyc - last_rise != per_q[0]) begin
					n_fail++;
					$display("MISMATCH %0t period %0d exp %0d", $time,
						cyc - last_rise, per_q[0]);
				end
				void'(per_q.pop_front());
			end
			last_rise <= cyc;
		end
	end

	// Verdict and end of run
	task automatic end_of_test();
		$display("checks %0d errors %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_of_test

	// Byte address of a register index
	function automatic logic [31:0] ba(input logic [9:0] i);
		return {20'h0, i, 2'b00};
	endfunction : ba

	// One single transfer; holds each phase until ready is sampled
	task automatic bus(input logic [31:0] a, input logic w,
		input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask : bus

	task automatic wr(input logic [9:0] i, input logic [31:0] d);
		bus(ba(i), 1'b1, d);
	endtask : wr

	// Read with expectation; c = {check irq, expected irq}
	task automatic rd(input logic [9:0] i, input logic [31:0] d,
		input logic [1:0] c = 2'b00);
		exp_q.push_back({c, d});
		bus(ba(i), 1'b0, 32'h0);
	endtask : rd

	// Bounded by the watchdog
	task automatic wait_rise();
		do @(posedge hclk); while (!(underflow_request === 1'b1 && !req_q));
	endtask : wait_rise

	// Expect the spacing between the next two underflows
	task automatic measure(input int per);
		wait_rise();
		@(posedge hclk);
		per_q.push_back(per);
		wait_rise();
	endtask : measure

	// Configure a source, load n, start and measure the period
	task automatic run(input logic [3:0] src, input logic [1:0] nar,
		input logic hv, input logic [15:0] n, input int per);
		wr(IDX_START, 32'h0);
		wr(IDX_SRC_SEL, {28'h0, src});
		wr(IDX_MODE, {24'h0, nar, 6'h00});
		wr(IDX_PCLK, {31'h0, hv});
		wr(IDX_COUNTER, {16'h0, n});
		wr(IDX_PRESCALE, 32'h1);
		wr(IDX_START, 32'h1);
		measure(per);
	endtask : run

	// Hang guard
	initial begin
		repeat (30000) @(posedge hclk);
		n_fail++;
		$display("MISMATCH %0t watchdog expired", $time);
		end_of_test();
	end

	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		div_cnt = 8'h00;
		slow_oscillator_clock = 1'b0;
		subclock_32k = 1'b0;
		rd_phase = 1'b0;
		req_q = 1'b0;
		{cyc, last_rise, n_fail, checks_done} = '0;
		void'($urandom(45776));
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		// Reset values, irq low
		rd(IDX_COUNTER, 32'(COUNT_RESET), 2'b10);
		rd(IDX_START, 32'(START_RESET));
		rd(IDX_MODE, 32'(MODE_RESET));
		rd(IDX_SRC_SEL, 32'(SRC_SEL_RESET));
		rd(IDX_PCLK, 32'(PCLK_RESET));
		rd(IDX_CLK_STOP, 32'(CLK_STOP_RESET));
		rd(IDX_STATUS, 32'h0);
		rd(IDX_MASK, 32'(MASK_RESET));
		// Unmapped place aliasing the counter index: ignored, reads zero
		bus(32'h0001_0cc0, 1'b1, 32'hffff_ffff);
		exp_q.push_back(34'h0);
		bus(32'h0001_0cc0, 1'b0, 32'h0);
		// Stopped writes load the counter, boundary first
		for (int k = 0; k < 4; k++) begin
			v = (k == 0) ? 16'hffff : 16'($urandom);
			wr(IDX_COUNTER, {16'h0, v});
			rd(IDX_COUNTER, {16'h0, v});
		end
		wr(IDX_CLK_STOP, 32'h0);
		// Every source selection with its period
		run(4'h0, NARROW_BASE, 1'b1, 16'h5, 6);
		run(4'h0, NARROW_BASE, 1'b0, 16'h3, 8);
		run(4'h0, NARROW_DIV8, 1'b0, 16'h1, 16);
		run(4'h0, NARROW_DIV32, 1'b0, 16'h1, 64);
		run(4'h0, NARROW_SUB, 1'b0, 16'h1, 32);
		run({1'b1, WIDE_BASE}, NARROW_SUB, 1'b1, 16'h2, 3);
		run({1'b1, WIDE_DIV8}, NARROW_BASE, 1'b1, 16'h2, 24);
		run({1'b1, WIDE_DIV32}, NARROW_BASE, 1'b1, 16'h1, 64);
		run({1'b1, WIDE_DIV64}, NARROW_BASE, 1'b1, 16'h1, 128);
		run({1'b1, WIDE_SLOW}, NARROW_BASE, 1'b1, 16'h2, 24);
		run({1'b1, WIDE_SUB}, NARROW_BASE, 1'b1, 16'h1, 32);
		// Sticky status, masked then unmasked, then cleared
		wr(IDX_START, 32'h0);
		rd(IDX_STATUS, 32'h1, 2'b10);
		wr(IDX_MASK, 32'h1);
		rd(IDX_STATUS, 32'h1, 2'b11);
		wr(IDX_STATUS, 32'h1);
		rd(IDX_STATUS, 32'h0, 2'b10);
		rd(IDX_MASK, 32'h1);
		// Stopped counter holds its value
		wr(IDX_COUNTER, 32'h7);
		repeat (200) @(posedge hclk);
		rd(IDX_COUNTER, 32'h7);
		// Write after start but before the first tick loads both
		wr(IDX_SRC_SEL, {28'h0, 1'b1, WIDE_DIV64});
		wr(IDX_PRESCALE, 32'h1);
		wr(IDX_START, 32'h1);
		wr(IDX_COUNTER, 32'h10);
		wr(IDX_START, 32'h0);
		rd(IDX_COUNTER, 32'h10);
		// After the first tick only the reload takes the write
		wr(IDX_START, 32'h1);
		repeat (100) @(posedge hclk);
		wr(IDX_COUNTER, 32'h3);
		repeat (320) @(posedge hclk);
		rd(IDX_STATUS, 32'h0);
		measure(256);
		// A non-timer operation mode freezes a started counter
		wr(IDX_START, 32'h0);
		wr(IDX_COUNTER, 32'h5);
		wr(IDX_SRC_SEL, {28'h0, 1'b1, WIDE_BASE});
		wr(IDX_MODE, 32'h1);
		wr(IDX_START, 32'h1);
		repeat (20) @(posedge hclk);
		rd(IDX_COUNTER, 32'h5);
		// Unused wide codes give no ticks in timer mode
		wr(IDX_SRC_SEL, 32'hc);
		wr(IDX_MODE, 32'h0);
		repeat (20) @(posedge hclk);
		rd(IDX_COUNTER, 32'h5);
		wr(IDX_SRC_SEL, 32'hf);
		repeat (20) @(posedge hclk);
		rd(IDX_COUNTER, 32'h5);
		end_of_test();
	end
endmodule : reload_down_timer_tb

bind reload_down_timer reload_down_timer_properties
	u_reload_down_timer_properties (.hclk, .hresetn, .hsel, .htrans,
	.hwrite, .hready, .hreadyout, .hresp, .hrdata, .underflow_request,
	.irq, .channel_input_pin_claim);
`default_nettype wire
